// ### csa_pkg.sv
// Shared constants and carrier types for the carry-select arithmetic cluster
package csa_pkg;

  // ---------------------------------------------------------------
  // Cluster geometry
  // ---------------------------------------------------------------
  localparam int CSA_CELLS = 8;                  // Logic cells per logic cluster

  // ---------------------------------------------------------------
  // APB register map
  // ---------------------------------------------------------------
  localparam int          CSA_ADDR_W     = 12;
  localparam logic [11:0] CSA_OFS_CTRL   = 12'h000;
  localparam logic [11:0] CSA_OFS_STATUS = 12'h004;
  localparam logic [31:0] CSA_CTRL_RST   = 32'h0000_0000;

  // Control register fields
  localparam int CSA_CTRL_CNT_MODE = 0;          // Register feeds back as operand_a
  localparam int CSA_CTRL_FREEZE   = 1;          // Software hold of the cell registers

  // Status register fields
  localparam int CSA_ST_SUM_LSB   = 0;
  localparam int CSA_ST_ZERO_OUT  = 8;
  localparam int CSA_ST_ONE_OUT   = 9;
  localparam int CSA_ST_CNT_MODE  = 16;
  localparam int CSA_ST_FREEZE    = 17;

  // ---------------------------------------------------------------
  // Counter steps and constant words
  // ---------------------------------------------------------------
  localparam logic [CSA_CELLS-1:0] CSA_STEP_UP   = 8'h01;
  localparam logic [CSA_CELLS-1:0] CSA_STEP_DOWN = 8'hff;
  localparam logic [CSA_CELLS-1:0] CSA_ZERO_WORD = 8'h00;
  localparam logic [31:0]          CSA_ZERO_32   = 32'h0000_0000;

  // ---------------------------------------------------------------
  // Carrier types
  // ---------------------------------------------------------------
  // Control lines: local data inputs and cluster-wide lines together
  typedef struct packed {
    logic clk_en;        // Cluster clock enable
    logic count_en;      // Counter enable, local data input
    logic count_up;      // Count direction, local data input
    logic sync_clr;      // Cluster-wide synchronous clear
    logic sync_load;     // Cluster-wide synchronous load
    logic add_nsub;      // Cluster-wide add (1) / subtract (0)
  } csa_ctrl_type;

  // The pair of carry-select chains
  typedef struct packed {
    logic carry_chain_zero;
    logic carry_chain_one;
  } csa_chain_type;

endpackage

// ### csa_logic_cell.sv
// One logic cell in dynamic arithmetic mode: four two-input lookup functions
`timescale 1ns/10ps
`default_nettype none

module csa_logic_cell (
  input  wire logic operand_a,
  input  wire logic operand_b,
  input  wire logic add_nsub,
  input  wire logic cluster_carry_in,
  input  wire logic carry_chain_zero_in,
  input  wire logic carry_chain_one_in,
  output logic      sum_comb,
  output logic      carry_chain_zero_out,
  output logic      carry_chain_one_out
);

  logic b_eff;
  logic sum_if_zero;
  logic sum_if_one;
  logic cout_if_zero;
  logic cout_if_one;
  logic chain_level;

  // Operand b inverted for subtraction
  assign b_eff = operand_b ^ ~add_nsub;

  // Two sum lookups, one per assumed carry
  assign sum_if_zero = operand_a ^ b_eff;
  assign sum_if_one  = ~(operand_a ^ b_eff);

  // Two carry lookups, one per assumed carry
  assign cout_if_zero = operand_a & b_eff;
  assign cout_if_one  = operand_a | b_eff;

  // Each chain's carry selects that chain's carry output
  assign carry_chain_zero_out = carry_chain_zero_in ? cout_if_one : cout_if_zero;
  assign carry_chain_one_out  = carry_chain_one_in ? cout_if_one : cout_if_zero;

  // Cluster carry picks the chain, chain level picks the sum
  assign chain_level = cluster_carry_in ? carry_chain_one_in : carry_chain_zero_in;
  assign sum_comb    = chain_level ? sum_if_one : sum_if_zero;

endmodule

`default_nettype wire

// ### csa_cluster.sv
// Logic cluster of carry-select arithmetic cells with APB control and status
//
// The implementer's own choices: the address map and register access over APB.
`timescale 1ns/10ps
`default_nettype none

module csa_cluster
  import csa_pkg::*;
(
  input  wire logic                               MCLK,
  input  wire logic                               RST,
  input  wire logic                               PSEL,
  input  wire logic                               PENABLE,
  input  wire logic                               PWRITE,
  input  wire logic [csa_pkg::CSA_ADDR_W-1:0]     PADDR,
  input  wire logic [31:0]                        PWDATA,
  output logic      [31:0]                        PRDATA,
  output logic                                    PREADY,
  output logic                                    PSLVERR,
  input  wire logic [csa_pkg::CSA_CELLS-1:0]      OPERAND_A,
  input  wire logic [csa_pkg::CSA_CELLS-1:0]      OPERAND_B,
  input  wire logic [csa_pkg::CSA_CELLS-1:0]      LOAD_DATA,
  input  wire csa_pkg::csa_ctrl_type              CTRL,
  input  wire logic                               CLUSTER_CARRY_IN,
  input  wire csa_pkg::csa_chain_type             CHAIN_IN,
  output csa_pkg::csa_chain_type                  CHAIN_OUT,
  output logic      [csa_pkg::CSA_CELLS-1:0]      SUM_COMB,
  output logic      [csa_pkg::CSA_CELLS-1:0]      SUM_REG
);
  import csa_pkg::*;

  // ---------------------------------------------------------------
  // Declarations
  // ---------------------------------------------------------------
  logic [31:0]          ctrl_q;
  logic                 pready_q;
  logic [31:0]          prdata_q;
  logic                 pslverr_q;
  logic [CSA_CELLS-1:0] sum_q;
  logic [CSA_CELLS-1:0] sum_d;
  logic [CSA_CELLS-1:0] sum_comb;
  logic [CSA_CELLS-1:0] op_a;
  logic [CSA_CELLS-1:0] op_b;
  logic                 add_nsub;
  logic [CSA_CELLS:0]   zero_c;
  logic [CSA_CELLS:0]   one_c;
  logic                 cnt_mode;
  logic                 freeze;
  logic                 reg_ce;
  logic                 apb_access;
  logic                 apb_done;

  // Address decode for the two registers
  function automatic logic csa_hit(input logic [CSA_ADDR_W-1:0] addr, input logic [CSA_ADDR_W-1:0] ofs);
    csa_hit = (addr == ofs);
  endfunction

  // ---------------------------------------------------------------
  // APB slave
  // ---------------------------------------------------------------
  assign apb_access = PSEL & PENABLE;
  assign apb_done   = apb_access & pready_q;

  // One wait state, then a one-cycle ready
  always_ff @(posedge MCLK or posedge RST) begin
    if (RST) begin
      pready_q <= 1'b0;
    end else begin
      pready_q <= apb_access & ~pready_q;
    end
  end

  // Read data and error captured as ready rises
  always_ff @(posedge MCLK or posedge RST) begin
    if (RST) begin
      prdata_q  <= CSA_ZERO_32;
      pslverr_q <= 1'b0;
    end else if (apb_access & ~pready_q) begin
      prdata_q  <= CSA_ZERO_32;
      pslverr_q <= 1'b0;
      if (csa_hit(PADDR, CSA_OFS_CTRL)) begin
        prdata_q <= PWRITE ? CSA_ZERO_32 : ctrl_q;
      end else if (csa_hit(PADDR, CSA_OFS_STATUS)) begin
        if (!PWRITE) begin
          prdata_q[CSA_ST_SUM_LSB +: CSA_CELLS] <= sum_q;
          prdata_q[CSA_ST_ZERO_OUT]            <= zero_c[CSA_CELLS];
          prdata_q[CSA_ST_ONE_OUT]             <= one_c[CSA_CELLS];
          prdata_q[CSA_ST_CNT_MODE]            <= cnt_mode;
          prdata_q[CSA_ST_FREEZE]              <= freeze;
        end
      end else begin
        pslverr_q <= 1'b1;                      // Unmapped address
      end
    end else begin
      pslverr_q <= 1'b0;
    end
  end

  // Control register, written at the completing edge
  always_ff @(posedge MCLK or posedge RST) begin
    if (RST) begin
      ctrl_q <= CSA_CTRL_RST;
    end else if (apb_done & PWRITE & csa_hit(PADDR, CSA_OFS_CTRL)) begin
      ctrl_q <= CSA_ZERO_32;
      ctrl_q[CSA_CTRL_CNT_MODE] <= PWDATA[CSA_CTRL_CNT_MODE];
      ctrl_q[CSA_CTRL_FREEZE]   <= PWDATA[CSA_CTRL_FREEZE];
    end
  end

  assign cnt_mode = ctrl_q[CSA_CTRL_CNT_MODE];
  assign freeze   = ctrl_q[CSA_CTRL_FREEZE];
  assign PREADY   = pready_q;
  assign PRDATA   = prdata_q;
  assign PSLVERR  = pslverr_q;

  // ---------------------------------------------------------------
  // Operand steering
  // ---------------------------------------------------------------
  // Counter mode feeds the register back and steps by one
  always_comb begin
    op_a     = OPERAND_A;
    op_b     = OPERAND_B;
    add_nsub = CTRL.add_nsub;
    if (cnt_mode) begin
      op_a     = sum_q;
      op_b     = CTRL.count_up ? CSA_STEP_UP : CSA_STEP_DOWN;
      add_nsub = 1'b1;
    end
  end

  // ---------------------------------------------------------------
  // Cell array on the two carry chains
  // ---------------------------------------------------------------
  assign zero_c[0] = CHAIN_IN.carry_chain_zero;
  assign one_c[0]  = CHAIN_IN.carry_chain_one;

  for (genvar i = 0; i < CSA_CELLS; i++) begin : g_cell
    csa_logic_cell u_cell (
      .operand_a            (op_a[i]),
      .operand_b            (op_b[i]),
      .add_nsub             (add_nsub),
      .cluster_carry_in     (CLUSTER_CARRY_IN),
      .carry_chain_zero_in  (zero_c[i]),
      .carry_chain_one_in   (one_c[i]),
      .sum_comb             (sum_comb[i]),
      .carry_chain_zero_out (zero_c[i+1]),
      .carry_chain_one_out  (one_c[i+1])
    );
  end

  // Combinational copy and chain carries leave the cluster directly
  assign SUM_COMB                   = sum_comb;
  assign CHAIN_OUT.carry_chain_zero = zero_c[CSA_CELLS];
  assign CHAIN_OUT.carry_chain_one  = one_c[CSA_CELLS];

  // ---------------------------------------------------------------
  // Cell registers
  // ---------------------------------------------------------------
  assign reg_ce = CTRL.clk_en & ~freeze;

  // Clear over load over count or sum
  always_comb begin
    sum_d = sum_q;
    if (CTRL.sync_clr) begin
      sum_d = CSA_ZERO_WORD;
    end else if (CTRL.sync_load) begin
      sum_d = LOAD_DATA;
    end else if (!cnt_mode || CTRL.count_en) begin
      sum_d = sum_comb;
    end
  end

  // All cells update at one edge under the clock enable
  always_ff @(posedge MCLK or posedge RST) begin
    if (RST) begin
      sum_q <= CSA_ZERO_WORD;
    end else if (reg_ce) begin
      sum_q <= sum_d;
    end
  end

  assign SUM_REG = sum_q;

  // ---------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------
  logic [CSA_CELLS-1:0] ref_b;
  logic                 ref_cin;
  logic [CSA_CELLS:0]   ref_sum;
  logic [CSA_CELLS:0]   ref_zero;
  logic [CSA_CELLS:0]   ref_one;

  assign ref_b    = add_nsub ? op_b : ~op_b;
  assign ref_cin  = CLUSTER_CARRY_IN ? one_c[0] : zero_c[0];
  assign ref_sum  = {1'b0, op_a} + {1'b0, ref_b} + {{CSA_CELLS{1'b0}}, ref_cin};
  assign ref_zero = {1'b0, op_a} + {1'b0, ref_b} + {{CSA_CELLS{1'b0}}, zero_c[0]};
  assign ref_one  = {1'b0, op_a} + {1'b0, ref_b} + {{CSA_CELLS{1'b0}}, one_c[0]};

  sequence s_plain_update;
    reg_ce && !CTRL.sync_clr && !CTRL.sync_load;
  endsequence

  a_sum_selected: assert property (@(posedge MCLK) disable iff (RST)
    sum_comb == ref_sum[CSA_CELLS-1:0]) else $error("combinational sum wrong");
  a_zero_chain_out: assert property (@(posedge MCLK) disable iff (RST)
    zero_c[CSA_CELLS] == ref_zero[CSA_CELLS]) else $error("zero chain carry wrong");
  a_one_chain_out: assert property (@(posedge MCLK) disable iff (RST)
    one_c[CSA_CELLS] == ref_one[CSA_CELLS]) else $error("one chain carry wrong");
  a_clear_wins: assert property (@(posedge MCLK) disable iff (RST)
    reg_ce && CTRL.sync_clr |=> sum_q == CSA_ZERO_WORD) else $error("clear not taken");
  a_load_taken: assert property (@(posedge MCLK) disable iff (RST)
    reg_ce && !CTRL.sync_clr && CTRL.sync_load |=> sum_q == $past(LOAD_DATA))
    else $error("load not taken");
  a_hold_no_enable: assert property (@(posedge MCLK) disable iff (RST)
    !reg_ce |=> $stable(sum_q)) else $error("register moved without enable");
  a_register_copy: assert property (@(posedge MCLK) disable iff (RST)
    s_plain_update ##0 (!cnt_mode || CTRL.count_en) |=> sum_q == $past(sum_comb))
    else $error("register does not follow sum");
  a_count_gated: assert property (@(posedge MCLK) disable iff (RST)
    s_plain_update ##0 cnt_mode && !CTRL.count_en |=> $stable(sum_q))
    else $error("counter moved while disabled");
  // Setup cycle followed by the first access cycle
  sequence s_apb_setup_access;
    PSEL && !PENABLE ##1 PSEL && PENABLE;
  endsequence

  a_apb_answer: assert property (@(posedge MCLK) disable iff (RST)
    s_apb_setup_access |=> pready_q) else $error("apb answer late");

endmodule

`default_nettype wire

// ### csa_nbr_model.sv
// Neighbouring logic and cluster-wide lines feeding the arithmetic cluster
`timescale 1ns/10ps
`default_nettype none

module csa_nbr_model
  import csa_pkg::*;
(
  input  wire logic                          clk,
  output csa_pkg::csa_ctrl_type              ctrl,
  output logic      [csa_pkg::CSA_CELLS-1:0] op_a,
  output logic      [csa_pkg::CSA_CELLS-1:0] op_b,
  output logic      [csa_pkg::CSA_CELLS-1:0] load_data,
  output logic                               carry_sel,
  output csa_pkg::csa_chain_type             chain
);
  // Quiet levels at time zero
  initial begin
    ctrl = csa_ctrl_type'(6'h00);
    {op_a, op_b, load_data, carry_sel, chain} = '0;
  end

  // Launch new levels just after a rising edge; count enable and direction ride local data
  task automatic drive(input logic [7:0] a, input logic [7:0] b, input logic [7:0] ld,
                       input logic [5:0] c, input logic cs, input logic [1:0] ch);
    @(posedge clk);
    op_a      <= a;
    op_b      <= b;
    load_data <= ld;
    ctrl      <= csa_ctrl_type'(c);
    carry_sel <= cs;
    chain     <= csa_chain_type'(ch);
  endtask
endmodule
`default_nettype wire

// ### csa_cluster_test.sv
// Self-checking bench for the carry-select arithmetic cluster
`timescale 1ns/10ps
`default_nettype none
`define CHK(g, e) begin num_checks++; if ((g) !== (e)) begin n_fail++; \
  $display("unexpected at %0t: got %h exp %h", $time, g, e); end end

module csa_cluster_test;
  import csa_pkg::*;
  logic                 MCLK = 1'b0;
  logic                 RST = 1'b1;
  logic                 PSEL = 1'b0;
  logic                 PENABLE = 1'b0;
  logic                 PWRITE = 1'b0;
  logic [11:0]          PADDR = 12'h000;
  logic [31:0]          PWDATA = 32'h0;
  wire logic [31:0]     PRDATA;
  wire logic            PREADY;
  wire logic            PSLVERR;
  wire csa_ctrl_type    CTRL;
  wire csa_chain_type   CHAIN_IN;
  wire csa_chain_type   CHAIN_OUT;
  wire logic [7:0]      OPERAND_A;
  wire logic [7:0]      OPERAND_B;
  wire logic [7:0]      LOAD_DATA;
  wire logic [7:0]      SUM_COMB;
  wire logic [7:0]      SUM_REG;
  wire logic            CLUSTER_CARRY_IN;
  int                   n_fail = 0;
  int                   num_checks = 0;
  logic [31:0]          rd;
  logic                 err;

  // ---------------------------------------------------------------
  // Clock, design and neighbours
  // ---------------------------------------------------------------
  initial begin
    forever #25 MCLK = ~MCLK;
  end

  csa_cluster dut (.MCLK(MCLK), .RST(RST), .PSEL(PSEL), .PENABLE(PENABLE), .PWRITE(PWRITE),
    .PADDR(PADDR), .PWDATA(PWDATA), .PRDATA(PRDATA), .PREADY(PREADY), .PSLVERR(PSLVERR),
    .OPERAND_A(OPERAND_A), .OPERAND_B(OPERAND_B), .LOAD_DATA(LOAD_DATA), .CTRL(CTRL),
    .CLUSTER_CARRY_IN(CLUSTER_CARRY_IN), .CHAIN_IN(CHAIN_IN), .CHAIN_OUT(CHAIN_OUT),
    .SUM_COMB(SUM_COMB), .SUM_REG(SUM_REG));

  csa_nbr_model nbr (.clk(MCLK), .ctrl(CTRL), .op_a(OPERAND_A), .op_b(OPERAND_B),
    .load_data(LOAD_DATA), .carry_sel(CLUSTER_CARRY_IN), .chain(CHAIN_IN));

  // ---------------------------------------------------------------
  // Helpers
  // ---------------------------------------------------------------
  // One APB transfer, held until the edge that samples PREADY high, released at that edge
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] wd);
    @(posedge MCLK);
    PSEL <= 1'b1;
    PENABLE <= 1'b0;
    PWRITE <= wr;
    PADDR <= a;
    PWDATA <= wd;
    @(posedge MCLK);
    PENABLE <= 1'b1;
    do begin
      @(posedge MCLK);
    end while (PREADY !== 1'b1);
    rd = PRDATA;
    err = PSLVERR;
    PSEL <= 1'b0;
    PENABLE <= 1'b0;
  endtask

  // Reference sum with carry out in bit 8
  function automatic logic [8:0] ref_sum(logic [7:0] a, logic [7:0] b, logic add, logic cin);
    ref_sum = {1'b0, a} + {1'b0, add ? b : ~b} + {8'h00, cin};
  endfunction

  // Verdict and end of run
  task automatic end_of_test;
    $display("checks %0d failures %0d", num_checks, n_fail);
    if (n_fail == 0 && num_checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask

  // ---------------------------------------------------------------
  // Scenarios
  // ---------------------------------------------------------------
  // Reset values and APB map, unmapped address refused
  task automatic t_regs;
    @(negedge MCLK);
    `CHK(SUM_REG, 8'h00)
    apb(1'b0, CSA_OFS_CTRL, 32'h0);
    `CHK({err, rd}, {1'b0, CSA_CTRL_RST})
    apb(1'b1, 12'h008, 32'h3);
    `CHK(err, 1'b1)
    apb(1'b0, 12'h008, 32'h0);
    `CHK({err, rd}, {1'b1, CSA_ZERO_32})
  endtask

  // Both chains, both selections, add and subtract; combinational then registered copy
  task automatic t_sums;
    logic [7:0] av[4] = '{8'hff, 8'h80, 8'h10, 8'h00};
    logic [7:0] bv[4] = '{8'h01, 8'h80, 8'h20, 8'hff};
    logic [8:0] e;
    logic [8:0] ez;
    logic [8:0] eo;
    for (int v = 0; v < 4; v++) begin
      for (int k = 0; k < 8; k++) begin
        nbr.drive(av[v], bv[v], 8'h00, {5'b10000, v[1]}, k[2], k[1:0]);
        e  = ref_sum(av[v], bv[v], v[1], k[2] ? k[0] : k[1]);
        ez = ref_sum(av[v], bv[v], v[1], k[1]);
        eo = ref_sum(av[v], bv[v], v[1], k[0]);
        @(negedge MCLK);
        `CHK(SUM_COMB, e[7:0])
        `CHK(CHAIN_OUT.carry_chain_zero, ez[8])
        `CHK(CHAIN_OUT.carry_chain_one, eo[8])
        @(negedge MCLK);
        `CHK(SUM_REG, e[7:0])
      end
    end
  endtask

  // Counter up, down and hold through local enables
  task automatic t_count;
    apb(1'b1, CSA_OFS_CTRL, 32'h1);
    apb(1'b0, CSA_OFS_CTRL, 32'h0);
    `CHK({err, rd}, {1'b0, 32'h0000_0001})
    nbr.drive(8'h00, 8'h00, 8'h00, 6'h24, 1'b0, 2'b00);
    nbr.drive(8'h00, 8'h00, 8'h00, 6'h38, 1'b0, 2'b00);
    repeat (3) @(posedge MCLK);
    @(negedge MCLK);
    `CHK(SUM_REG, 8'h03)
    nbr.drive(8'h00, 8'h00, 8'h00, 6'h30, 1'b0, 2'b00);
    repeat (2) @(posedge MCLK);
    @(negedge MCLK);
    `CHK(SUM_REG, 8'h02)
    nbr.drive(8'h00, 8'h00, 8'h00, 6'h20, 1'b0, 2'b00);
    repeat (3) @(posedge MCLK);
    apb(1'b0, CSA_OFS_STATUS, 32'h0);
    `CHK(rd & 32'h0003_00ff, 32'h0001_0001)
    apb(1'b1, CSA_OFS_CTRL, 32'h0);
  endtask

  // Load, clear over load, clock enable and freeze gating
  task automatic t_clr_load;
    nbr.drive(8'h00, 8'h00, 8'h5a, 6'h22, 1'b0, 2'b00);
    nbr.drive(8'h00, 8'h00, 8'h5a, 6'h26, 1'b0, 2'b00);
    @(negedge MCLK);
    `CHK(SUM_REG, 8'h5a)
    @(negedge MCLK);
    `CHK(SUM_REG, 8'h00)
    nbr.drive(8'h00, 8'h00, 8'h5a, 6'h22, 1'b0, 2'b00);
    nbr.drive(8'h00, 8'h00, 8'h5a, 6'h04, 1'b0, 2'b00);
    repeat (2) @(negedge MCLK);
    `CHK(SUM_REG, 8'h5a)
    apb(1'b1, CSA_OFS_CTRL, 32'h2);
    nbr.drive(8'h00, 8'h00, 8'h00, 6'h24, 1'b0, 2'b00);
    repeat (2) @(negedge MCLK);
    `CHK(SUM_REG, 8'h5a)
    apb(1'b1, CSA_OFS_CTRL, 32'h0);
    repeat (2) @(negedge MCLK);
    `CHK(SUM_REG, 8'h00)
  endtask

  // ---------------------------------------------------------------
  // Main sequence and watchdog
  // ---------------------------------------------------------------
  initial begin
    repeat (10) @(posedge MCLK);
    RST <= 1'b0;
    t_regs();
    t_sums();
    t_count();
    t_clr_load();
    end_of_test();
  end

  initial begin
    repeat (4000) @(posedge MCLK);
    n_fail++;
    end_of_test();
  end
endmodule
`default_nettype wire
